// [verilog/fdc_cmd_params.svh]
// offsets, opcodes, reset values and timing counts of the command sequencer
// assumes byte addressing on a 32-bit apb bus
`ifndef FDC_CMD_PARAMS_SVH
`define FDC_CMD_PARAMS_SVH

`define OFS_DATA          12'h000
`define OFS_MAIN_STATUS   12'h004
`define OFS_IRQ_STATUS    12'h008
`define OFS_IRQ_ENABLE    12'h00C
`define OFS_IRQ_CLEAR     12'h010

`define MS_BIT_RQM        7
`define MS_BIT_DIO        6
`define MS_BIT_EXEC       5
`define MS_BIT_BUSY       4

`define IRQ_BIT_CMD_DONE  0
`define IRQ_BIT_RECAL     1
`define IRQ_BIT_INVALID   2
`define IRQ_RESET         3'h0

`define OP_LOW_VERIFY     5'h16
`define OP_LOW_WRITE      5'h05
`define OP_LOW_WRITE_DEL  5'h09
`define OP_LOW_FORMAT     5'h0D
`define OP_RECAL          8'h07
`define OP_VERSION        8'h10
`define RES_VERSION       8'h90
`define RES_INVALID       8'h80

`define PARAM_RW          4'h8
`define PARAM_FORMAT      4'h5
`define PARAM_RECAL       4'h1
`define RES_RW            3'h7
`define RES_ONE           3'h1

`define CLK_PERIOD_NS     20
`define STEP_TIME_NS      3000
`define STEP_CYC          ((`STEP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MAX_STEPS         8'h50

`endif

// [verilog/fdc_cmd_pkg.sv]
// types shared by the command sequencer and its bench
// assumes fdc_cmd_params.svh for numeric constants
package fdc_cmd_pkg;

  typedef enum logic [2:0] {
    PH_IDLE   = 3'b000,
    PH_PARAM  = 3'b001,
    PH_EXEC   = 3'b010,
    PH_RESULT = 3'b011,
    PH_RECAL  = 3'b100
  } phase_t;

  typedef enum logic [2:0] {
    K_VERIFY    = 3'b000,
    K_WRITE     = 3'b001,
    K_WRITE_DEL = 3'b010,
    K_FORMAT    = 3'b011,
    K_RECAL     = 3'b100,
    K_VERSION   = 3'b101,
    K_INVALID   = 3'b110
  } cmd_kind_t;

  // selection and mode fields presented to the drive logic
  typedef struct packed {
    logic       multi_track;
    logic       double_density;
    logic       skip_marked;
    logic       verify_count_mode;
    logic       side_select;
    logic       drive_sel_hi;
    logic       drive_sel_lo;
    cmd_kind_t  kind;
  } drive_ctl_t;

  // end-of-execution report from the drive logic
  typedef struct packed {
    logic       done;
    logic       ready;
    logic [7:0] result_status_zero;
    logic [7:0] result_status_one;
    logic [7:0] result_status_two;
  } drive_report_t;

  // byte stream towards the floppy_drive
  typedef struct packed {
    logic       valid;
    logic       deleted;
    logic [7:0] data;
  } stream_t;

endpackage

// [verilog/sync2.sv]
// two-flop synchroniser for asynchronous levels
// assumes inputs are quasi-static levels
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// [verilog/param_mem.sv]
// small parameter byte store with registered read data
// assumes a single clock; no reset on contents
`timescale 1ns/1ps
`default_nettype none
module param_mem #(
  parameter int W = 8,
  parameter int D = 8,
  parameter int A = 3
) (
  input  wire logic         clk,
  input  wire logic         we,
  input  wire logic [A-1:0] waddr,
  input  wire logic [W-1:0] wdata,
  input  wire logic [A-1:0] raddr,
  output var  logic [W-1:0] rdata_q
);
  logic [W-1:0] mem [D];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end
endmodule
`default_nettype wire

// [verilog/fdc_cmd_seq.sv]
// command-phase decoder and sequencer with apb register access
// assumes drive logic on pclk; track-zero sense arrives from a pin
//
// Contract
// RULE1 - verify opcode: flags in bits 7..5, 10110 low; count-mode bit 7 of byte two
// RULE2 - write data: flags bits 7..6, bit 5 zero, 00101 low; streams data
// RULE3 - write deleted data: low bits 01001, same parameters, deleted marks
// RULE4 - host sends drive byte then cylinder, head, record, size, final, gap, length
// RULE5 - verify and writes return three status bytes then cylinder, head, record, size
// RULE6 - recalibrate 07h plus drive byte: step to track zero, interrupt, no result
// RULE7 - undefined opcode is a no-operation returning one status byte of 80h
// RULE8 - host follows recalibrate interrupt with sense interrupt status; 08h decodes as an undefined opcode here
// RULE9 - format: drive, size, sectors, gap, filler; four bytes per sector; seven results
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fdc_cmd_params.svh"
module fdc_cmd_seq #(
  parameter int STEP_CYCLES = `STEP_CYC,
  parameter int MAX_STEPS   = `MAX_STEPS
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output var  logic [31:0]                prdata,
  output var  logic                       pready,
  output var  logic                       pslverr,
  output var  logic                       irq,
  input  wire logic                       track_zero_pin,
  input  wire fdc_cmd_pkg::drive_report_t report,
  output var  fdc_cmd_pkg::drive_ctl_t    drive_ctl,
  output var  fdc_cmd_pkg::stream_t       stream,
  output var  logic                       exec_start,
  output var  logic                       step,
  output var  logic                       step_outward
);
  import fdc_cmd_pkg::*;

  typedef struct packed {
    phase_t     phase;
    drive_ctl_t ctl;
    logic [3:0] pidx;
    logic [3:0] pcnt;
    logic [2:0] ridx;
    logic [2:0] rcnt;
    logic [7:0] st0;
    logic [7:0] st1;
    logic [7:0] st2;
    logic [7:0] sectors;
    logic [9:0] fmt_cnt;
    logic [15:0] step_cnt;
    logic [7:0] steps;
    logic [2:0] irq_stat;
    logic [2:0] irq_en;
    logic       irq;
    logic       pready;
    logic       pslverr;
    logic [31:0] prdata;
    logic       exec_start;
    logic       step;
    stream_t    stream;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic       trk0;
  logic [7:0] mem_rdata;
  logic       mem_we;
  logic [2:0] mem_raddr;

  //////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [2:0] reg_sel(input logic [11:0] a);
    unique case (a)
      `OFS_DATA:        reg_sel = 3'h1;
      `OFS_MAIN_STATUS: reg_sel = 3'h2;
      `OFS_IRQ_STATUS:  reg_sel = 3'h3;
      `OFS_IRQ_ENABLE:  reg_sel = 3'h4;
      `OFS_IRQ_CLEAR:   reg_sel = 3'h5;
      default:          reg_sel = 3'h0;
    endcase
  endfunction

  function automatic cmd_kind_t decode(input logic [7:0] op);
    if (op[4:0] == `OP_LOW_VERIFY) begin
      decode = K_VERIFY; // RULE1
    end else if (!op[5] && op[4:0] == `OP_LOW_WRITE) begin
      decode = K_WRITE; // RULE2
    end else if (!op[5] && op[4:0] == `OP_LOW_WRITE_DEL) begin
      decode = K_WRITE_DEL; // RULE3
    end else if (!op[7] && !op[5] && op[4:0] == `OP_LOW_FORMAT) begin
      decode = K_FORMAT; // RULE9
    end else if (op == `OP_RECAL) begin
      decode = K_RECAL; // RULE6
    end else if (op == `OP_VERSION) begin
      decode = K_VERSION;
    end else begin
      decode = K_INVALID; // RULE7
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // submodules

  sync2 #(.W(1)) u_trk0 (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (track_zero_pin),
    .q     (trk0)
  );

  param_mem #(.W(8), .D(8), .A(3)) u_mem (
    .clk     (pclk),
    .we      (mem_we),
    .waddr   (s_q.pidx[2:0]),
    .wdata   (pwdata[7:0]),
    .raddr   (mem_raddr),
    .rdata_q (mem_rdata)
  );

  // result bytes 3..6 read cylinder, head, record, size from slots 1..4
  assign mem_raddr = s_q.ridx - 3'h2;

  //////////////////////////////////////////////////////////////////////////
  // next state

  logic       acc;
  logic       done_acc;
  logic [2:0] sel;
  logic       rqm;
  logic       dio;
  logic       data_wr;
  logic       data_rd;
  logic [7:0] res_byte;
  logic       in_stream;
  cmd_kind_t  k;

  always_comb begin
    s_d       = s_q;
    acc       = psel && penable;
    done_acc  = acc && s_q.pready;
    sel       = reg_sel(paddr);
    in_stream = (s_q.ctl.kind == K_WRITE) || (s_q.ctl.kind == K_WRITE_DEL) ||
                (s_q.ctl.kind == K_FORMAT && s_q.fmt_cnt < {s_q.sectors, 2'b00});
    dio       = (s_q.phase == PH_RESULT);
    unique case (s_q.phase)
      PH_IDLE, PH_PARAM, PH_RESULT: rqm = 1'b1;
      PH_EXEC:  rqm = in_stream && report.ready && !s_q.stream.valid;
      default:  rqm = 1'b0;
    endcase
    data_wr   = done_acc && pwrite && sel == 3'h1 && rqm && !dio;
    data_rd   = done_acc && !pwrite && sel == 3'h1 && dio;
    mem_we    = data_wr && s_q.phase == PH_PARAM;
    k         = decode(pwdata[7:0]);
    if (s_q.ridx < 3'h3) begin
      res_byte = (s_q.ridx == 3'h0) ? s_q.st0 : (s_q.ridx == 3'h1) ? s_q.st1 : s_q.st2;
    end else begin
      res_byte = (s_q.ctl.kind == K_FORMAT) ? 8'h00 : mem_rdata;
    end

    s_d.exec_start   = 1'b0;
    s_d.stream.valid = 1'b0;
    s_d.step         = 1'b0;

    // apb: first access cycle loads the answer, second completes it
    s_d.pready  = acc && !s_q.pready;
    s_d.pslverr = acc && !s_q.pready && sel == 3'h0;
    s_d.prdata  = 32'h0000_0000;
    if (acc && !s_q.pready && !pwrite) begin
      unique case (sel)
        3'h1: s_d.prdata = {24'h00_0000, dio ? res_byte : 8'h00};
        3'h2: s_d.prdata = {24'h00_0000, rqm, dio, s_q.phase == PH_EXEC,
                            s_q.phase != PH_IDLE, 1'b0, s_q.phase};
        3'h3: s_d.prdata = {29'h0000_0000, s_q.irq_stat};
        3'h4: s_d.prdata = {29'h0000_0000, s_q.irq_en};
        default: s_d.prdata = 32'h0000_0000;
      endcase
    end
    if (done_acc && pwrite && sel == 3'h4) begin
      s_d.irq_en = pwdata[2:0];
    end
    if (done_acc && pwrite && sel == 3'h5) begin
      s_d.irq_stat = s_q.irq_stat & ~pwdata[2:0];
    end

    unique case (s_q.phase)
      PH_IDLE: begin
        if (data_wr) begin
          s_d.ctl.kind           = k;
          s_d.ctl.multi_track    = pwdata[7];
          s_d.ctl.double_density = pwdata[6];
          s_d.ctl.skip_marked    = (k == K_VERIFY) && pwdata[5]; // RULE1
          s_d.pidx               = 4'h0;
          s_d.ridx               = 3'h0;
          s_d.fmt_cnt            = 10'h000;
          unique case (k)
            K_VERIFY, K_WRITE, K_WRITE_DEL: begin
              s_d.pcnt  = `PARAM_RW; // RULE4
              s_d.phase = PH_PARAM;
            end
            K_FORMAT: begin
              s_d.pcnt  = `PARAM_FORMAT; // RULE9
              s_d.phase = PH_PARAM;
            end
            K_RECAL: begin
              s_d.pcnt  = `PARAM_RECAL; // RULE6
              s_d.phase = PH_PARAM;
            end
            K_VERSION: begin
              s_d.st0   = `RES_VERSION;
              s_d.rcnt  = `RES_ONE;
              s_d.phase = PH_RESULT;
            end
            default: begin
              s_d.st0   = `RES_INVALID; // RULE7
              s_d.rcnt  = `RES_ONE; // RULE7
              s_d.phase = PH_RESULT;
              s_d.irq_stat[`IRQ_BIT_INVALID] = 1'b1;
            end
          endcase
        end
      end
      PH_PARAM: begin
        if (data_wr) begin
          if (s_q.pidx == 4'h0) begin
            s_d.ctl.verify_count_mode = (s_q.ctl.kind == K_VERIFY) && pwdata[7]; // RULE1
            s_d.ctl.side_select       = (s_q.ctl.kind != K_RECAL) && pwdata[2]; // RULE4
            s_d.ctl.drive_sel_hi      = pwdata[1];
            s_d.ctl.drive_sel_lo      = pwdata[0];
          end
          if (s_q.pidx == 4'h2 && s_q.ctl.kind == K_FORMAT) begin
            s_d.sectors = pwdata[7:0]; // RULE9
          end
          s_d.pidx = s_q.pidx + 4'h1;
          if (s_q.pidx + 4'h1 == s_q.pcnt) begin
            if (s_q.ctl.kind == K_RECAL) begin
              s_d.steps    = 8'h00;
              s_d.step_cnt = 16'h0000;
              s_d.phase    = PH_RECAL;
            end else begin
              s_d.exec_start = 1'b1;
              s_d.phase      = PH_EXEC;
            end
          end
        end
      end
      PH_EXEC: begin
        if (data_wr) begin
          s_d.stream.valid   = 1'b1; // RULE2
          s_d.stream.data    = pwdata[7:0];
          s_d.stream.deleted = (s_q.ctl.kind == K_WRITE_DEL); // RULE3
          s_d.fmt_cnt        = s_q.fmt_cnt + 10'h001; // RULE9
        end
        if (report.done) begin
          s_d.st0   = report.result_status_zero; // RULE5
          s_d.st1   = report.result_status_one;
          s_d.st2   = report.result_status_two;
          s_d.rcnt  = `RES_RW; // RULE5
          s_d.phase = PH_RESULT;
          s_d.irq_stat[`IRQ_BIT_CMD_DONE] = 1'b1;
        end
      end
      PH_RESULT: begin
        if (data_rd) begin
          s_d.ridx = s_q.ridx + 3'h1;
          if (s_q.ridx + 3'h1 == s_q.rcnt) begin
            s_d.phase = PH_IDLE;
          end
        end
      end
      PH_RECAL: begin
        // step outward at the step rate until track zero or the step limit
        if (s_q.step_cnt != 16'h0000) begin
          s_d.step_cnt = s_q.step_cnt - 16'h0001;
        end else if (trk0 || s_q.steps == MAX_STEPS[7:0]) begin
          s_d.phase = PH_IDLE; // RULE6
          s_d.irq_stat[`IRQ_BIT_RECAL] = 1'b1; // RULE6
        end else begin
          s_d.step     = 1'b1; // RULE6
          s_d.steps    = s_q.steps + 8'h01;
          s_d.step_cnt = STEP_CYCLES[15:0];
        end
      end
      default: begin
        s_d.phase = PH_IDLE;
      end
    endcase

    s_d.irq = |(s_d.irq_stat & s_d.irq_en);
  end

  //////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata       = s_q.prdata;
  assign pready       = s_q.pready;
  assign pslverr      = s_q.pslverr;
  assign irq          = s_q.irq;
  assign drive_ctl    = s_q.ctl;
  assign stream       = s_q.stream;
  assign exec_start   = s_q.exec_start;
  assign step         = s_q.step;
  assign step_outward = 1'b1;

endmodule
`default_nettype wire

// [verification/fdc_cmd_seq_assertions.sv]
// port-level checks of the command sequencer
// assumes the bind below onto every fdc_cmd_seq
`timescale 1ns/1ps
`default_nettype none
module fdc_cmd_seq_assertions
  import fdc_cmd_pkg::*;
(
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire fdc_cmd_pkg::drive_ctl_t    drive_ctl,
  input wire fdc_cmd_pkg::stream_t       stream,
  input wire logic                       exec_start,
  input wire logic                       step,
  input wire logic                       step_outward
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  property p_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_wait: assert property (p_wait) else $error("apb answer late");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  property p_rdzero;
    !pready |-> prdata == 32'h0000_0000;
  endproperty
  a_rdzero: assert property (p_rdzero) else $error("prdata not zero outside answer");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_dir;
    step_outward;
  endproperty
  a_dir: assert property (p_dir) else $error("step direction not outward");
  property p_step;
    step |-> drive_ctl.kind == K_RECAL && !drive_ctl.side_select ##1 !step;
  endproperty
  a_step: assert property (p_step) else $error("step outside recalibrate");
  property p_nodata;
    stream.valid |-> drive_ctl.kind inside {K_WRITE, K_WRITE_DEL, K_FORMAT};
  endproperty
  a_nodata: assert property (p_nodata) else $error("stream byte for verify");
  property p_del;
    stream.valid |-> stream.deleted == (drive_ctl.kind == K_WRITE_DEL) ##1 !stream.valid;
  endproperty
  a_del: assert property (p_del) else $error("deleted mark wrong");
  property p_exec;
    exec_start |-> drive_ctl.kind != K_RECAL ##1 !exec_start [*3];
  endproperty
  a_exec: assert property (p_exec) else $error("exec start wrong");
  c_exec: cover property (exec_start);
  c_step: cover property (step);
  c_strm: cover property (stream.valid && stream.deleted);
  c_err: cover property (pslverr);
endmodule
bind fdc_cmd_seq fdc_cmd_seq_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .drive_ctl(drive_ctl), .stream(stream), .exec_start(exec_start), .step(step),
  .step_outward(step_outward));
`default_nettype wire

// [verification/drive_model.sv]
// behavioural drive side: head position, stream readiness, end report
// assumes the bench raises go for one cycle to end execution
`timescale 1ns/1ps
`default_nettype none
module drive_model
  import fdc_cmd_pkg::*;
(
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       step,
  input  wire logic                       stall,
  input  wire logic                       go,
  input  wire logic [23:0]                st,
  input  wire logic [7:0]                 zero_at,
  output var  fdc_cmd_pkg::drive_report_t report,
  output var  logic                       track_zero_pin
);
  logic [7:0] steps_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) steps_q <= 8'h00;
    else if (step) steps_q <= steps_q + 8'h01;
  end
  // head reaches track zero after zero_at outward steps
  assign track_zero_pin = (steps_q >= zero_at);
  // status lines hold garbage except in the done cycle
  always_comb begin
    report.done = go;
    report.ready = !stall;
    {report.result_status_zero, report.result_status_one, report.result_status_two} =
      go ? st : ~st;
  end
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// self-checking bench of the command sequencer over apb
// assumes drive_model on the far side and the checker bound in
`timescale 1ns/1ps
`default_nettype none
`include "fdc_cmd_params.svh"
module tb_top;
  import fdc_cmd_pkg::*;
  logic          pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic          stall = 1'b0, go = 1'b0, err, last_del;
  logic [11:0]   paddr = 12'h000;
  logic [31:0]   pwdata = 32'h0000_0000, prdata, rd;
  logic [23:0]   st = 24'h41_1234;
  logic [7:0]    zero_at = 8'hFF, last_b;
  logic          pready, pslverr, irq, tz, exec_start, step, step_out;
  drive_report_t report;
  drive_ctl_t    drive_ctl;
  stream_t       stream;
  int            n_fail = 0, check_count = 0, n_exec = 0, n_step = 0, n_strm = 0;
  always #10 pclk = ~pclk;
  fdc_cmd_seq #(.STEP_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .track_zero_pin(tz), .report(report),
    .drive_ctl(drive_ctl), .stream(stream), .exec_start(exec_start), .step(step),
    .step_outward(step_out));
  drive_model u_drv (.pclk(pclk), .presetn(presetn), .step(step), .stall(stall), .go(go),
    .st(st), .zero_at(zero_at), .report(report), .track_zero_pin(tz));
  always @(posedge pclk) begin
    if (exec_start === 1'b1) n_exec++;
    if (step === 1'b1) n_step++;
    if (stream.valid === 1'b1) begin
      n_strm++;
      last_b = stream.data;
      last_del = stream.deleted;
    end
  end
  ////////////////////////////////////////
  task finish_test;
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      n_fail++;
      finish_test;
    end
  endtask
  task wait_bit(input logic [11:0] a, input int b);
    int i;
    for (i = 0; i < 200; i++) begin
      apb(1'b0, a, 0);
      if (rd[b] === 1'b1) break;
    end
    if (i == 200) begin
      n_fail++;
      finish_test;
    end
  endtask
  ////////////////////////////////////////
  task one_byte(input logic [7:0] op, input logic [7:0] exp);
    apb(1'b1, `OFS_DATA, op);
    apb(1'b0, `OFS_MAIN_STATUS, 0);
    chk(rd & 32'h0000_00C7, 8'hC3);
    apb(1'b0, `OFS_DATA, 0);
    chk(rd, exp);
    apb(1'b0, `OFS_MAIN_STATUS, 0);
    chk(rd[2:0], 3'h0);
  endtask
  task s_irq;
    apb(1'b0, `OFS_IRQ_STATUS, 0);
    chk(rd, 3'h4);
    apb(1'b0, `OFS_IRQ_ENABLE, 0);
    chk(rd, 0);
    chk(irq, 1'b0);
    apb(1'b1, `OFS_IRQ_ENABLE, 3'h7);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    apb(1'b1, `OFS_IRQ_CLEAR, 3'h4);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    apb(1'b0, 12'h020, 0);
    chk(err, 1'b1);
    chk(rd, 0);
  endtask
  task s_recal;
    zero_at <= 8'h03;
    apb(1'b1, `OFS_DATA, 8'h07);
    apb(1'b1, `OFS_DATA, 8'h05);
    wait_bit(`OFS_IRQ_STATUS, 1);
    chk(n_step, 3);
    chk(irq, 1'b1);
    apb(1'b0, `OFS_MAIN_STATUS, 0);
    chk(rd[2:0], 3'h0);
    apb(1'b1, `OFS_IRQ_CLEAR, 3'h2);
  endtask
  task run(input logic [7:0] op, input logic [7:0] drv, input int np, input int nd,
           input cmd_kind_t k);
    int i, e, s;
    logic fmt;
    fmt = (k == K_FORMAT);
    e = n_exec;
    s = n_strm;
    apb(1'b1, `OFS_DATA, op);
    apb(1'b1, `OFS_DATA, drv);
    for (i = 0; i < np - 1; i++) apb(1'b1, `OFS_DATA, 8'h20 + i);
    repeat (2) @(posedge pclk);
    chk(n_exec - e, 1);
    chk(drive_ctl, {op[7:6], (k == K_VERIFY) & op[5], (k == K_VERIFY) & drv[7], drv[2:0], k});
    for (i = 0; i < nd; i++) begin
      if (i == 1) begin
        stall <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b0, `OFS_MAIN_STATUS, 0);
        chk(rd[7], 1'b0);
        stall <= 1'b0;
      end
      wait_bit(`OFS_MAIN_STATUS, 7);
      apb(1'b1, `OFS_DATA, 8'hA0 + i);
    end
    repeat (2) @(posedge pclk);
    chk(n_strm - s, nd);
    if (nd > 0) chk({last_del, last_b}, {k == K_WRITE_DEL, 8'(8'hA0 + nd - 1)});
    apb(1'b0, `OFS_MAIN_STATUS, 0);
    if (fmt) chk(rd[7], 1'b0);
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    wait_bit(`OFS_IRQ_STATUS, 0);
    for (i = 0; i < 7; i++) begin
      apb(1'b0, `OFS_DATA, 0);
      chk(rd, i < 3 ? 32'((st >> (16 - 8 * i)) & 24'hFF) : fmt ? 0 : 32'(8'h20 + i - 3));
    end
    apb(1'b0, `OFS_MAIN_STATUS, 0);
    chk(rd[2:0], 3'h0);
    apb(1'b1, `OFS_IRQ_CLEAR, 3'h7);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    one_byte(8'h10, 8'h90);
    one_byte(8'h00, 8'h80);
    one_byte(8'hE5, 8'h80);
    s_irq;
    s_recal;
    run(8'hF6, 8'h86, 8, 0, K_VERIFY);
    run(8'hC5, 8'h05, 8, 2, K_WRITE);
    run(8'h49, 8'h02, 8, 2, K_WRITE_DEL);
    run(8'h4D, 8'h07, 5, 132, K_FORMAT);
    finish_test;
  end
endmodule
`default_nettype wire
